/* verilog/adc_ctrl_defines.vh */
// constants shared by the converter control and host interface logic
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH

// result word and byte lane layout
`define RESULT_W 12
`define RESULT_MSB 11
`define LOW_BYTE_MSB 7
`define HIGH_NIB_MSB 11
`define HIGH_NIB_LSB 8
`define HIGH_PAD 4'h0
`define BUS_W 8

// serial lanes repurposed from the parallel bus
`define LANE_STROBE 5
`define LANE_SCLK 6
`define LANE_DOUT 7

// conversion length in conversion clock falling edges
`define END_EDGE 4'hd
`define EDGE_CNT_W 4
`define EDGE_ZERO 4'h0
`define EDGE_ONE 4'h1

// timing: core clock period and internal oscillator rate
`define CORE_PERIOD_NS 100
`define OSC_FREQ_KHZ 1000
// half period of oscillator in core cycles, rounded down, at least one
`define OSC_HALF_CYC ((1000000 / (`OSC_FREQ_KHZ * 2 * `CORE_PERIOD_NS)) < 1 ? \
    1 : (1000000 / (`OSC_FREQ_KHZ * 2 * `CORE_PERIOD_NS)))
`define OSC_CNT_W 8

// one-hot states
`define ST_IDLE 2'b01
`define ST_CONV 2'b10

`endif

/* verilog/adc_host_ctrl.v */
// control, conversion sequencing and host interface of a 12-bit sampler
`timescale 1ns/1ps
`include "adc_ctrl_defines.vh"

module adc_host_ctrl #(
    parameter OSC_HALF = `OSC_HALF_CYC
) (
    // clock and reset
    input wire core_clk_in,
    input wire resetn_in,
    // mode straps from the board
    input wire power_down_n_in,
    input wire power_down_open_in,
    input wire polarity_select_in,
    input wire interface_select_in,
    input wire int_osc_select_in,
    // host control strobes
    input wire chip_select_n_in,
    input wire read_n_in,
    input wire high_byte_select_in,
    // conversion clock pin, serial clock in serial mode
    input wire conv_clk_in,
    // raw successive-approximation word from the analog core
    input wire [`RESULT_W-1:0] sample_in,
    // power and reference state
    output reg converter_active_out,
    output reg ext_ref_comp_out,
    // conversion status
    output reg busy_n_out,
    // data lines, enable low while driven
    output reg [`BUS_W-1:0] data_out,
    output reg [`BUS_W-1:0] data_oe_n_out
);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    ////////////////////////////////////////////////////////////////////////

    reg [6:0] sync1_reg;
    reg [6:0] sync2_reg;
    reg [`RESULT_W-1:0] sample1_reg;
    reg [`RESULT_W-1:0] sample2_reg;

    // two flops on every pin, first stage read only by the second
    always @(posedge core_clk_in) begin
        if (!resetn_in) begin
            sync1_reg <= 7'h1f;
            sync2_reg <= 7'h1f;
            sample1_reg <= 12'h000;
            sample2_reg <= 12'h000;
        end else begin
            sync1_reg <= {int_osc_select_in, conv_clk_in, high_byte_select_in,
                read_n_in, chip_select_n_in, power_down_open_in,
                power_down_n_in};
            sync2_reg <= sync1_reg;
            sample1_reg <= sample_in;
            sample2_reg <= sample1_reg;
        end
    end

    reg [2:0] strap1_reg;
    reg [2:0] strap2_reg;

    // polarity and interface straps on a second pair so the bundle above stays readable
    always @(posedge core_clk_in) begin
        if (!resetn_in) begin
            strap1_reg <= 3'h0;
            strap2_reg <= 3'h0;
        end else begin
            strap1_reg <= {interface_select_in, polarity_select_in, 1'b0};
            strap2_reg <= strap1_reg;
        end
    end

    wire pd_n = sync2_reg[0];
    wire pd_open = sync2_reg[1];
    wire cs_n = sync2_reg[2];
    wire rd_n = sync2_reg[3];
    wire high_byte_select = sync2_reg[4];
    wire ext_clk = sync2_reg[5];
    wire use_osc = sync2_reg[6];
    wire bipolar = strap2_reg[1];
    wire parallel = strap2_reg[2];

    ////////////////////////////////////////////////////////////////////////
    // conversion clock: pin or internal oscillator
    ////////////////////////////////////////////////////////////////////////

    reg [`OSC_CNT_W-1:0] osc_cnt_reg;
    reg osc_reg;

    // the oscillator is modelled as a divider of the core clock; it stops
    // in power-down, just as the real capacitor oscillator is gated off
    always @(posedge core_clk_in) begin
        if (!resetn_in || !pd_n) begin
            osc_cnt_reg <= 8'h00;
            osc_reg <= 1'b0;
        end else if (osc_cnt_reg == OSC_HALF[`OSC_CNT_W-1:0] - 8'h01) begin
            osc_cnt_reg <= 8'h00;
            osc_reg <= ~osc_reg;
        end else begin
            osc_cnt_reg <= osc_cnt_reg + 8'h01;
        end
    end

    wire cclk = use_osc ? osc_reg : ext_clk;
    reg cclk_d_reg;
    reg cs_n_d_reg;
    reg rd_n_d_reg;

    // previous values for edge detection, all on synchronised signals
    always @(posedge core_clk_in) begin
        if (!resetn_in) begin
            cclk_d_reg <= 1'b0;
            cs_n_d_reg <= 1'b1;
            rd_n_d_reg <= 1'b1;
        end else begin
            cclk_d_reg <= cclk;
            cs_n_d_reg <= cs_n;
            rd_n_d_reg <= rd_n;
        end
    end

    wire cclk_fall = cclk_d_reg & ~cclk;
    wire cclk_rise = ~cclk_d_reg & cclk;

    ////////////////////////////////////////////////////////////////////////
    // start detection
    ////////////////////////////////////////////////////////////////////////

    // parallel: the later of cs and read going low opens the access
    wire acc_now = ~cs_n & ~rd_n;
    wire acc_prev = ~cs_n_d_reg & ~rd_n_d_reg;
    wire par_start = parallel & acc_now & ~acc_prev & ~high_byte_select;
    wire ser_start = ~parallel & ~cs_n & cs_n_d_reg & ~high_byte_select;
    wire start_req = (par_start | ser_start) & pd_n;

    // output coding applied to the raw word
    function [`RESULT_W-1:0] code_word;
        input [`RESULT_W-1:0] raw;
        input polarity_select;
        begin
            code_word = raw;
            code_word[`RESULT_MSB] = raw[`RESULT_MSB] ^ polarity_select;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // conversion sequencer
    ////////////////////////////////////////////////////////////////////////

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [`EDGE_CNT_W-1:0] edge_reg;
    reg [`EDGE_CNT_W-1:0] edge_next;
    reg [`RESULT_W-1:0] held_reg;
    reg [`RESULT_W-1:0] held_next;
    reg [`RESULT_W-1:0] result_reg;
    reg strobe_reg;
    reg strobe_next;
    reg sdata_reg;
    reg sdata_next;

    // one-hot sequencer; the word is held at start like the track/hold
    always @* begin
        state_next = state_reg;
        edge_next = edge_reg;
        held_next = held_reg;
        strobe_next = strobe_reg;
        sdata_next = sdata_reg;
        case (state_reg)
            `ST_IDLE: begin
                if (start_req) begin
                    state_next = `ST_CONV;
                    edge_next = `EDGE_ZERO;
                    held_next = code_word(sample2_reg, bipolar);
                    strobe_next = 1'b0;
                    sdata_next = 1'b0;
                end
            end
            `ST_CONV: begin
                // further starts fall through here unseen
                if (!pd_n) begin
                    state_next = `ST_IDLE;
                    strobe_next = 1'b0;
                end else if (cclk_rise && edge_reg == `EDGE_ZERO) begin
                    strobe_next = 1'b1; // announces the msb
                end else if (cclk_fall) begin
                    edge_next = edge_reg + `EDGE_ONE;
                    strobe_next = 1'b0;
                    // one bit per falling edge, msb first
                    sdata_next = held_reg[`RESULT_MSB];
                    held_next = {held_reg[`RESULT_MSB-1:0], held_reg[0]};
                    if (edge_reg + `EDGE_ONE == `END_EDGE) begin
                        state_next = `ST_IDLE;
                    end
                end
            end
            default: begin
                state_next = `ST_IDLE;
            end
        endcase
    end

    reg [`RESULT_W-1:0] shadow_reg;

    // result is copied at start and written to the buffer only at the end,
    // so the previous result stays readable during a conversion
    always @(posedge core_clk_in) begin
        if (!resetn_in) begin
            state_reg <= `ST_IDLE;
            edge_reg <= `EDGE_ZERO;
            held_reg <= 12'h000;
            shadow_reg <= 12'h000;
            result_reg <= 12'h000;
            strobe_reg <= 1'b0;
            sdata_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            edge_reg <= edge_next;
            held_reg <= held_next;
            strobe_reg <= strobe_next;
            sdata_reg <= sdata_next;
            if (state_reg == `ST_IDLE && start_req) begin
                shadow_reg <= code_word(sample2_reg, bipolar);
            end
            if (state_reg == `ST_CONV && state_next == `ST_IDLE && pd_n) begin
                result_reg <= shadow_reg;
            end
        end
    end

    wire converting = (state_reg == `ST_CONV);

    ////////////////////////////////////////////////////////////////////////
    // output registers
    ////////////////////////////////////////////////////////////////////////

    reg [`BUS_W-1:0] par_word;
    reg [`BUS_W-1:0] bus_next;
    reg [`BUS_W-1:0] oe_n_next;
    reg sclk_run;

    // lane and enable selection for both interface modes
    always @* begin
        if (high_byte_select) begin
            par_word = {`HIGH_PAD,
                result_reg[`HIGH_NIB_MSB:`HIGH_NIB_LSB]};
        end else begin
            par_word = result_reg[`LOW_BYTE_MSB:0];
        end
        sclk_run = (converting | high_byte_select) & cclk;
        bus_next = 8'h00;
        oe_n_next = 8'hff;
        if (parallel) begin
            bus_next = par_word;
            if (acc_now) begin
                oe_n_next = 8'h00;
            end
        end else begin
            bus_next[`LANE_STROBE] = strobe_reg;
            bus_next[`LANE_SCLK] = sclk_run;
            bus_next[`LANE_DOUT] = sdata_reg;
            if (!cs_n) begin
                oe_n_next[`LANE_DOUT] = 1'b0;
                if (!rd_n) begin
                    oe_n_next[`LANE_STROBE] = 1'b0;
                    oe_n_next[`LANE_SCLK] = 1'b0;
                end
            end
        end
    end

    // every top output leaves from a flop
    always @(posedge core_clk_in) begin
        if (!resetn_in) begin
            busy_n_out <= 1'b1;
            data_out <= 8'h00;
            data_oe_n_out <= 8'hff;
            converter_active_out <= 1'b0;
            ext_ref_comp_out <= 1'b0;
        end else begin
            busy_n_out <= ~(converting & ~(state_next == `ST_IDLE));
            data_out <= bus_next;
            data_oe_n_out <= oe_n_next;
            converter_active_out <= pd_n | pd_open;
            ext_ref_comp_out <= pd_open;
        end
    end

endmodule

/* sim/adc_host_chk.sv */
// assertion checker for the converter control and host interface
`timescale 1ns/1ps
module adc_host_chk #(
    parameter OSC_HALF = 5
) (
    // clock, reset and straps
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic power_down_n_in,
    input wire logic power_down_open_in,
    input wire logic interface_select_in,
    // host strobes
    input wire logic chip_select_n_in,
    input wire logic read_n_in,
    input wire logic high_byte_select_in,
    // outputs watched
    input wire logic converter_active_out,
    input wire logic ext_ref_comp_out,
    input wire logic busy_n_out,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_oe_n_out
);
    // bench clock is 8 core cycles; the oscillator may be slower
    localparam int MAX_LO = 120 + 26 * OSC_HALF;
    int lo_cnt;

    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (!resetn_in);

    ////////////////////////////////////////////////////////////////////////
    // length of the current busy-low stretch
    always @(posedge core_clk_in) begin
        if (!resetn_in || busy_n_out)
            lo_cnt <= 0;
        else
            lo_cnt <= lo_cnt + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    // inputs must be held a few cycles to cover the sync chains
    a_pd_halt: assert property ((!power_down_n_in && !power_down_open_in)[*4]
        |-> !converter_active_out && busy_n_out)
        else $error("power-down did not halt the converter");
    a_open_ext: assert property (power_down_open_in[*4]
        |-> ext_ref_comp_out && converter_active_out)
        else $error("open power pin did not give external comp");
    a_high_byte_select_nostart: assert property ((high_byte_select_in && busy_n_out)[*5]
        |=> busy_n_out)
        else $error("conversion started with high byte select high");
    a_par_float: assert property ((interface_select_in
        && chip_select_n_in)[*5] |-> data_oe_n_out == 8'hff)
        else $error("parallel lines driven while deselected");
    a_par_drive: assert property ((interface_select_in && !chip_select_n_in
        && !read_n_in)[*5] |-> data_oe_n_out == 8'h00)
        else $error("parallel lines not driven during read");
    a_ser_float: assert property ((!interface_select_in
        && chip_select_n_in)[*5] |-> data_oe_n_out[7:5] == 3'b111)
        else $error("serial lines driven while deselected");
    a_ser_rdfloat: assert property ((!interface_select_in && read_n_in)[*5]
        |-> data_oe_n_out[6:5] == 2'b11)
        else $error("serial clock or strobe driven with read high");
    a_upper_pad: assert property ((interface_select_in && high_byte_select_in
        && !chip_select_n_in && !read_n_in)[*5] |-> data_out[7:4] == 4'h0)
        else $error("upper byte lines not low");
    a_busy_min: assert property ($fell(busy_n_out) |-> !busy_n_out[*8])
        else $error("busy released too early");
    a_busy_bound: assert property (lo_cnt <= MAX_LO)
        else $error("busy held too long");
endmodule

bind adc_host_ctrl adc_host_chk #(.OSC_HALF(OSC_HALF)) chk_u (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .power_down_n_in(power_down_n_in),
    .power_down_open_in(power_down_open_in),
    .interface_select_in(interface_select_in),
    .chip_select_n_in(chip_select_n_in), .read_n_in(read_n_in),
    .high_byte_select_in(high_byte_select_in),
    .converter_active_out(converter_active_out),
    .ext_ref_comp_out(ext_ref_comp_out), .busy_n_out(busy_n_out),
    .data_out(data_out), .data_oe_n_out(data_oe_n_out)
);

/* sim/host_model.sv */
// microprocessor host model driving the converter's strobes
`timescale 1ns/1ps
module host_model (
    // bench clocks, and status and data from the converter
    input wire logic clk_in,
    input wire logic cclk_in,
    input wire logic busy_n_in,
    input wire logic [7:0] data_in,
    // strobes to the converter
    output logic cs_n_out,
    output logic rd_n_out,
    output logic high_byte_select_out
);
    int busy_lo;

    // chip select and read idle high, high byte select low, from time zero
    initial begin
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        high_byte_select_out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // byte read; waits out any conversion it starts, counting busy cycles
    task automatic par_read(input logic hb, input logic cs,
                            output logic [7:0] v);
        busy_lo = 0;
        @(posedge clk_in) #1;
        high_byte_select_out = hb; // set up before the strobes
        @(posedge clk_in) #1;
        cs_n_out = !cs;
        rd_n_out = 1'b0;
        for (int i = 0; i < 200 && !(busy_lo > 0 && busy_n_in); i++) begin
            @(posedge clk_in);
            if (!busy_n_in)
                busy_lo++;
        end
        repeat (3) @(posedge clk_in);
        #1;
        v = data_in;
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
    endtask

    // serial read: start just after a clock fall, take a bit at each fall from the second on
    task automatic ser_read(output logic [11:0] v);
        @(negedge cclk_in);
        @(posedge clk_in) #1;
        cs_n_out = 1'b0;
        rd_n_out = 1'b0;
        for (int k = 1; k <= 13; k++) begin
            @(negedge cclk_in);
            if (k >= 2)
                v[13 - k] = data_in[7]; // msb first
        end
        for (int i = 0; i < 40 && !busy_n_in; i++)
            @(posedge clk_in);
        @(posedge clk_in) #1;
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
    endtask
endmodule

/* sim/tb.sv */
// self-checking bench for the converter control and host interface
`timescale 1ns/1ps
module tb;
    logic core_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic pd_n = 1'b1;
    logic pd_open = 1'b0;
    logic polarity_select = 1'b0;
    logic par = 1'b1;
    logic osc = 1'b0;
    logic cclk = 1'b0;
    logic [11:0] smp = 12'h000;
    logic cs_n, rd_n, high_byte_select, act, ext_ref, busy_n;
    logic [7:0] dout, doe_n, bv;
    logic [11:0] wv;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;

    adc_host_ctrl #(.OSC_HALF(1)) dut_u (
        .core_clk_in(core_clk_in), .resetn_in(resetn_in),
        .power_down_n_in(pd_n), .power_down_open_in(pd_open),
        .polarity_select_in(polarity_select), .interface_select_in(par),
        .int_osc_select_in(osc), .chip_select_n_in(cs_n),
        .read_n_in(rd_n), .high_byte_select_in(high_byte_select),
        .conv_clk_in(cclk), .sample_in(smp),
        .converter_active_out(act), .ext_ref_comp_out(ext_ref),
        .busy_n_out(busy_n), .data_out(dout), .data_oe_n_out(doe_n)
    );
    host_model host_u (
        .clk_in(core_clk_in), .cclk_in(cclk), .busy_n_in(busy_n),
        .data_in(dout), .cs_n_out(cs_n), .rd_n_out(rd_n),
        .high_byte_select_out(high_byte_select)
    );

    ////////////////////////////////////////////////////////////////////////
    // core clock, and a conversion clock offset so edges never coincide
    initial forever #50 core_clk_in = ~core_clk_in;
    initial begin
        #25;
        forever #400 cclk = ~cclk;
    end

    // cut a hang short
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 10000) begin
            miscompares++;
            final_report();
        end
    end

    task automatic chk(input string what, input logic [11:0] e,
                       input logic [11:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // low byte starts a conversion, high byte only reads
    task automatic t_parallel(input logic [11:0] s, input logic b);
        logic [11:0] c;
        c = {s[11] ^ b, s[10:0]};
        @(posedge core_clk_in) #1;
        smp = s;
        polarity_select = b;
        host_u.par_read(1'b0, 1'b1, bv);
        chk("busy_len", 1, host_u.busy_lo inside {[96:106]});
        chk("low_byte", c[7:0], bv);
        host_u.par_read(1'b1, 1'b1, bv);
        chk("no_start", 0, host_u.busy_lo);
        chk("high_byte", {4'h0, c[11:8]}, bv);
        $display("test parallel done");
    endtask

    task automatic t_no_cs();
        host_u.par_read(1'b0, 1'b0, bv);
        chk("no_cs_start", 0, host_u.busy_lo);
        chk("no_cs_float", 8'hff, doe_n);
        $display("test deselected done");
    endtask

    task automatic t_power();
        @(posedge core_clk_in) #1;
        pd_n = 1'b0;
        repeat (5) @(posedge core_clk_in);
        #1;
        chk("pd_active", 0, act);
        host_u.par_read(1'b0, 1'b1, bv);
        chk("pd_start", 0, host_u.busy_lo);
        pd_n = 1'b1;
        pd_open = 1'b1;
        repeat (5) @(posedge core_clk_in);
        #1;
        chk("open_ext", 2'b11, {act, ext_ref});
        pd_open = 1'b0;
        repeat (5) @(posedge core_clk_in);
        #1;
        chk("high_int", 2'b10, {act, ext_ref});
        $display("test power done");
    endtask

    task automatic t_serial(input logic [11:0] s);
        @(posedge core_clk_in) #1;
        par = 1'b0;
        polarity_select = 1'b0;
        smp = s;
        repeat (5) @(posedge core_clk_in);
        host_u.ser_read(wv);
        chk("serial_word", s, wv);
        repeat (5) @(posedge core_clk_in);
        #1;
        chk("serial_float", 3'b111, doe_n[7:5]);
        par = 1'b1;
        $display("test serial done");
    endtask

    task automatic t_int_osc();
        @(posedge core_clk_in) #1;
        osc = 1'b1;
        smp = 12'h3e7;
        host_u.par_read(1'b0, 1'b1, bv);
        chk("osc_busy", 1, host_u.busy_lo inside {[20:32]});
        chk("osc_byte", 8'he7, bv);
        osc = 1'b0;
        $display("test oscillator done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (5) @(posedge core_clk_in);
        #1;
        resetn_in = 1'b1;
        repeat (4) @(posedge core_clk_in);
        t_parallel(12'h8c1, 1'b0);
        t_parallel(12'h5a3, 1'b1);
        t_no_cs();
        t_power();
        t_serial(12'ha5c);
        t_int_osc();
        final_report();
    end
endmodule
